// *** logic/rcs_arbiter.sv ***
// Purpose: shares the battery-backed cmos space between controller and host
// Assumes: controller bus on mclk, cmos array behind cmos_req, pins pass synchronisers
// Notes: both banks arbitrated by one control byte, indirect data access per bank
`timescale 1ns/1ps
`default_nettype none
`include "rcs_defines.svh"

module rcs_arbiter
  import rcs_pkg::*;
#(
  parameter logic [19:0] LOCKOUT_CYCLES = 20'(`RCS_LOCKOUT_CYCLES)
) (
  // clock and main-plane power-on reset
  input wire logic mclk,
  input wire logic rst_n,
  // controller memory bus
  input wire logic ctrl_rd,
  input wire logic ctrl_wr,
  input wire logic [15:0] ctrl_addr,
  input wire logic [7:0] ctrl_wdata,
  output logic [7:0] ctrl_rdata,
  // host cmos port
  input wire rcs_host_req_s host_req,
  output logic [7:0] host_rdata,
  // system pins, asynchronous
  input wire logic host_power_good,
  input wire logic standby_supply,
  input wire logic system_reset_output_n,
  input wire logic total_power_loss,
  // rtc divider mode from register a
  input wire logic divider_normal,
  // cmos array
  output rcs_cmos_req_s cmos_req,
  input wire logic [7:0] cmos_rdata,
  // status and rtc interrupt
  output logic osc_disable,
  output logic host_locked,
  output logic rtc_irq_oe,
  input wire logic rtc_irq_req
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  rcs_state_s state_reg; // all flops of the block
  rcs_state_s state_next; // next value
  rcs_owner_e own_lo; // owner of bank 0
  rcs_owner_e own_hi; // owner of bank 1
  logic ctrl_free; // controller may touch cmos without arbitration
  logic pg_now; // synchronised power-good
  logic host_ok; // host not locked out

  // owner of one bank from its two request bits and the flag
  function automatic rcs_owner_e bank_owner(input logic unaware, input logic creq,
                                            input logic hreq);
    if (unaware) begin
      bank_owner = RCS_OWN_HOST;
    end else if (hreq) begin
      bank_owner = RCS_OWN_HOST;
    end else if (creq) begin
      bank_owner = RCS_OWN_CTRL;
    end else begin
      bank_owner = RCS_OWN_NONE;
    end
  endfunction : bank_owner

  // control byte as read back; bits 6-4 stay zero
  function automatic logic [7:0] ctrl_byte(input rcs_state_s s);
    ctrl_byte = {s.unaware, 3'b000, s.creq_hi, s.hreq_hi, s.creq_lo, s.hreq_lo};
  endfunction : ctrl_byte

  // ----------------------------------------
  // combinational next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    cmos_req = '0;
    // two-flop synchronisers; only the second stage is read below
    state_next.pg_sync = {state_reg.pg_sync[0], host_power_good};
    state_next.sby_sync = {state_reg.sby_sync[0], standby_supply};
    state_next.rst_out_sync = {state_reg.rst_out_sync[0], system_reset_output_n};
    state_next.loss_sync = {state_reg.loss_sync[0], total_power_loss};
    pg_now = state_reg.pg_sync[1];
    own_lo = bank_owner(state_reg.unaware, state_reg.creq_lo, state_reg.hreq_lo);
    own_hi = bank_owner(state_reg.unaware, state_reg.creq_hi, state_reg.hreq_hi);
    // reset output active or standby off frees the controller
    ctrl_free = !state_reg.rst_out_sync[1] || !state_reg.sby_sync[1];
    // lockout counter: held while power-good low, counts down after in normal divider mode, cleared otherwise
    if (!pg_now) begin
      state_next.locked = 1'b1;
      state_next.lock_cnt = LOCKOUT_CYCLES;
    end else if (!divider_normal) begin
      state_next.locked = 1'b0;
      state_next.lock_cnt = '0;
    end else if (state_reg.lock_cnt != '0) begin
      state_next.lock_cnt = state_reg.lock_cnt - 20'h0001;
      state_next.locked = 1'b1;
    end else begin
      state_next.locked = 1'b0;
    end
    host_ok = !state_reg.locked || !divider_normal;
    // total power loss: zero registers 00-0D and stop the oscillator
    if (state_reg.loss_sync[1] && !state_reg.init_busy && !state_reg.osc_off) begin
      state_next.init_busy = 1'b1;
      state_next.init_addr = '0;
      state_next.osc_off = 1'b1;
    end
    if (state_reg.init_busy) begin
      // the init walk owns the array; other array accesses are dropped until it ends
      cmos_req.wr = 1'b1;
      cmos_req.addr = {1'b0, state_reg.init_addr};
      cmos_req.wdata = 8'h00;
      state_next.init_addr = state_reg.init_addr + 7'h01;
      if (state_reg.init_addr == `RCS_RTC_LAST) begin
        state_next.init_busy = 1'b0;
      end
    end
    if (!state_reg.loss_sync[1]) begin
      state_next.osc_off = 1'b0; // oscillator runs again once the synchronised power-loss pin drops
    end
    // controller register writes
    if (ctrl_wr) begin
      if (ctrl_addr == `RCS_OFS_CONTROL) begin
        state_next.unaware = ctrl_wdata[`RCS_BIT_UNAWARE];
        // requests granted only while the host bit is clear
        state_next.creq_lo = ctrl_wdata[`RCS_BIT_CREQ_LO] && !state_reg.hreq_lo;
        state_next.creq_hi = ctrl_wdata[`RCS_BIT_CREQ_HI] && !state_reg.hreq_hi;
        if (ctrl_wdata[`RCS_BIT_UNAWARE]) begin
          state_next.hreq_lo = 1'b0;
          state_next.hreq_hi = 1'b0;
        end
      end else if (ctrl_addr == `RCS_OFS_ADDR_LO) begin
        state_next.addr_lo = ctrl_wdata;
      end else if (ctrl_addr == `RCS_OFS_ADDR_HI) begin
        state_next.addr_hi = ctrl_wdata;
      end
    end
    // host writes to the mirror location set or drop host requests
    if (host_req.wr && host_ok && host_req.addr[6:0] == `RCS_CMOS_MIRROR) begin
      // same-cycle contest: host bit wins and controller bit is refused
      if (!state_reg.creq_lo || (ctrl_wr && ctrl_addr == `RCS_OFS_CONTROL)) begin
        // a same-cycle flag write keeps the host bits clear
        state_next.hreq_lo = host_req.wdata[`RCS_BIT_HREQ_LO] && !state_next.unaware;
      end
      if (!state_reg.creq_hi || (ctrl_wr && ctrl_addr == `RCS_OFS_CONTROL)) begin
        state_next.hreq_hi = host_req.wdata[`RCS_BIT_HREQ_HI] && !state_next.unaware;
      end
      if (ctrl_wr && ctrl_addr == `RCS_OFS_CONTROL) begin
        state_next.creq_lo = state_next.creq_lo && !host_req.wdata[`RCS_BIT_HREQ_LO];
        state_next.creq_hi = state_next.creq_hi && !host_req.wdata[`RCS_BIT_HREQ_HI];
      end
    end
    // controller data reads and writes through the granted bank
    state_next.ctrl_rdata = 8'h00;
    if (ctrl_rd) begin
      if (ctrl_addr == `RCS_OFS_CONTROL) begin
        state_next.ctrl_rdata = ctrl_byte(state_reg);
      end else if (ctrl_addr == `RCS_OFS_ADDR_LO) begin
        state_next.ctrl_rdata = state_reg.addr_lo;
      end else if (ctrl_addr == `RCS_OFS_ADDR_HI) begin
        state_next.ctrl_rdata = state_reg.addr_hi;
      end
    end
    if (!state_reg.init_busy && (ctrl_rd || ctrl_wr)) begin
      if (ctrl_addr == `RCS_OFS_DATA_LO && (own_lo == RCS_OWN_CTRL || ctrl_free)) begin
        // bit 7 of the address is dropped: bank 0 is 00-7F
        cmos_req.addr = {1'b0, state_reg.addr_lo[6:0]};
        cmos_req.rd = ctrl_rd;
        cmos_req.wr = ctrl_wr;
        cmos_req.wdata = ctrl_wdata;
        state_next.ctrl_rdata = ctrl_rd ? cmos_rdata : 8'h00;
      end else if (ctrl_addr == `RCS_OFS_DATA_HI && (own_hi == RCS_OWN_CTRL || ctrl_free)) begin
        cmos_req.addr = {1'b1, state_reg.addr_hi[6:0]};
        cmos_req.rd = ctrl_rd;
        cmos_req.wr = ctrl_wr;
        cmos_req.wdata = ctrl_wdata;
        state_next.ctrl_rdata = ctrl_rd ? cmos_rdata : 8'h00;
      end
    end
    // host cmos access: mirror read, else granted bank access
    state_next.host_rdata = 8'h00;
    if (host_req.rd && host_req.addr[6:0] == `RCS_CMOS_MIRROR) begin
      state_next.host_rdata = ctrl_byte(state_reg);
    end else if (!state_reg.init_busy && !cmos_req.rd && !cmos_req.wr &&
                 (host_req.rd || (host_req.wr && host_ok)) &&
                 host_req.addr[6:0] != `RCS_CMOS_MIRROR) begin
      if ((host_req.addr[7] ? own_hi : own_lo) == RCS_OWN_HOST) begin
        cmos_req.rd = host_req.rd;
        cmos_req.wr = host_req.wr;
        cmos_req.addr = host_req.addr;
        cmos_req.wdata = host_req.wdata;
        state_next.host_rdata = host_req.rd ? cmos_rdata : 8'h00;
      end
    end
    // power-on reset blocks every array access, even a free controller
    if (!rst_n) begin
      cmos_req = '0;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // all access is dead while rst_n is low: every flop sits at its constant
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
      state_reg.unaware <= 1'(`RCS_CONTROL_RST >> `RCS_BIT_UNAWARE);
      state_reg.addr_lo <= `RCS_ADDR_RST;
      state_reg.addr_hi <= `RCS_ADDR_RST;
      state_reg.locked <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign ctrl_rdata = state_reg.ctrl_rdata;
  assign host_rdata = state_reg.host_rdata;
  assign osc_disable = state_reg.osc_off;
  assign host_locked = state_reg.locked && divider_normal;
  // irq released while in reset; driven low only when asked after
  assign rtc_irq_oe = rst_n && rtc_irq_req;

endmodule : rcs_arbiter
`default_nettype wire

// *** logic/rcs_defines.svh ***
// Purpose: offsets, reset values, field positions and timing counts of the cmos share arbiter
// Assumes: controller clock mclk at 250 MHz
// Notes: definitions only
`ifndef RCS_DEFINES_SVH
`define RCS_DEFINES_SVH

// ----------------------------------------
// controller register offsets
// ----------------------------------------
`define RCS_OFS_CONTROL 16'h7FF5
`define RCS_OFS_ADDR_LO 16'h7FF6
`define RCS_OFS_DATA_LO 16'h7FF7
`define RCS_OFS_ADDR_HI 16'h7FF8
`define RCS_OFS_DATA_HI 16'h7FF9
// cmos location that mirrors the control register in each bank
`define RCS_CMOS_MIRROR 7'h7F
// last rtc register cleared after total power loss
`define RCS_RTC_LAST 7'h0D

// ----------------------------------------
// reset values and field positions
// ----------------------------------------
`define RCS_CONTROL_RST 8'h80
`define RCS_ADDR_RST 8'h00
`define RCS_BIT_UNAWARE 7
`define RCS_BIT_CREQ_HI 3
`define RCS_BIT_HREQ_HI 2
`define RCS_BIT_CREQ_LO 1
`define RCS_BIT_HREQ_LO 0

// ----------------------------------------
// timing
// ----------------------------------------
`define RCS_CLK_PERIOD_PS 4000
`define RCS_LOCKOUT_MIN_US 500
`define RCS_LOCKOUT_MAX_US 1000
// lockout sits between min and max: use the minimum rounded up
`define RCS_LOCKOUT_CYCLES ((`RCS_LOCKOUT_MIN_US * 1000000 + `RCS_CLK_PERIOD_PS - 1) / `RCS_CLK_PERIOD_PS)

`endif

// *** logic/rcs_pkg.sv ***
// Purpose: types for the cmos share arbiter
// Assumes: rcs_defines.svh holds the numbers
// Notes: types only
package rcs_pkg;

  // grant owner of one bank
  typedef enum logic [1:0] {
    RCS_OWN_NONE,
    RCS_OWN_CTRL,
    RCS_OWN_HOST
  } rcs_owner_e;

  // host port request into the cmos space
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rcs_host_req_s;

  // cmos array access towards the rtc core
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rcs_cmos_req_s;

  // whole state of the arbiter
  typedef struct packed {
    logic unaware;
    logic creq_hi;
    logic hreq_hi;
    logic creq_lo;
    logic hreq_lo;
    logic [7:0] addr_lo;
    logic [7:0] addr_hi;
    logic [7:0] ctrl_rdata;
    logic [7:0] host_rdata;
    logic [1:0] pg_sync;
    logic [1:0] sby_sync;
    logic [1:0] rst_out_sync;
    logic [1:0] loss_sync;
    logic [19:0] lock_cnt;
    logic locked;
    logic init_busy;
    logic [6:0] init_addr;
    logic osc_off;
  } rcs_state_s;

endpackage : rcs_pkg

// *** test/rcs_arbiter_checker.sv ***
// Purpose: port assertions for the cmos share arbiter
// Assumes: offsets from rcs_defines.svh
// Notes: bound into every rcs_arbiter
`timescale 1ns/1ps
`default_nettype none
`include "rcs_defines.svh"
module rcs_arbiter_checker
  import rcs_pkg::*;
#(
  parameter logic [19:0] LOCKOUT_CYCLES = 20'd20
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // controller bus
  input wire logic ctrl_rd,
  input wire logic ctrl_wr,
  input wire logic [15:0] ctrl_addr,
  input wire logic [7:0] ctrl_rdata,
  // host, cmos and status
  input wire rcs_host_req_s host_req,
  input wire rcs_cmos_req_s cmos_req,
  input wire logic [7:0] cmos_rdata,
  input wire logic divider_normal,
  input wire logic host_locked,
  input wire logic osc_disable,
  input wire logic rtc_irq_oe
);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_irq_float: assert property (disable iff (1'b0) !rst_n |-> !rtc_irq_oe)
    else $error("irq driver enabled in reset");
  chk_cmos_quiet: assert property (disable iff (1'b0)
    !rst_n |-> !(cmos_req.rd || cmos_req.wr))
    else $error("cmos touched in reset");
  chk_rdata_idle: assert property (!$past(ctrl_rd) |-> ctrl_rdata == 8'h00)
    else $error("read data without a read");
  // host traffic excluded: its own bank access may share the array port
  chk_bank_low: assert property ((ctrl_rd || ctrl_wr) && ctrl_addr == `RCS_OFS_DATA_LO
    && !(host_req.rd || host_req.wr) && (cmos_req.rd || cmos_req.wr) |-> !cmos_req.addr[7])
    else $error("low data left bank zero");
  chk_rdata_pass: assert property (ctrl_rd && !host_req.rd && cmos_req.rd
    |=> ctrl_rdata == $past(cmos_rdata))
    else $error("cmos byte not returned");
  chk_lock_div: assert property (host_locked |-> divider_normal)
    else $error("lockout outside normal mode");
  // controller writes and the power-loss walk may still use the array
  chk_lock_write: assert property (host_locked && host_req.wr && !ctrl_wr
    && !osc_disable |-> !cmos_req.wr)
    else $error("host write passed lockout");
  chk_ctl_zero: assert property ($past(ctrl_rd)
    && $past(ctrl_addr) == `RCS_OFS_CONTROL |-> ctrl_rdata[6:4] == 3'b000)
    else $error("control bits 6-4 not zero");
  // main scenarios seen
  cov_ctrl_read: cover property (ctrl_rd && cmos_req.rd);
  cov_locked_wr: cover property (host_locked && host_req.wr);
  cov_ctrl_write: cover property (ctrl_wr && cmos_req.wr);
endmodule : rcs_arbiter_checker
bind rcs_arbiter rcs_arbiter_checker #(.LOCKOUT_CYCLES(LOCKOUT_CYCLES)) u_rcs_arbiter_checker (
  .mclk(mclk), .rst_n(rst_n), .ctrl_rd(ctrl_rd), .ctrl_wr(ctrl_wr), .ctrl_addr(ctrl_addr),
  .ctrl_rdata(ctrl_rdata), .host_req(host_req), .cmos_req(cmos_req), .cmos_rdata(cmos_rdata),
  .divider_normal(divider_normal), .host_locked(host_locked), .osc_disable(osc_disable),
  .rtc_irq_oe(rtc_irq_oe));
`default_nettype wire

// *** test/rcs_arbiter_tb.sv ***
// Purpose: self-checking bench for the cmos share arbiter
// Assumes: lockout shortened to 20 cycles
// Notes: controller and host driven 1 ns after each edge
`timescale 1ns/1ps
`default_nettype none
`include "rcs_defines.svh"
module rcs_arbiter_tb
  import rcs_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic mclk = 0, rst_n = 0, ctrl_rd = 0, ctrl_wr = 0, pg = 1, div_n = 1;
  logic sysrst_n = 1, sby = 1, loss = 0, irq = 0, host_locked, osc, irq_oe;
  logic [7:0] host_rdata;
  logic [15:0] ctrl_addr = 16'h0000;
  logic [7:0] ctrl_wdata = 8'h00, ctrl_rdata, cmos_rdata;
  rcs_host_req_s host_req = '0;
  rcs_cmos_req_s cmos_req;
  int n_fail = 0, n_tests = 0, cyc = 0;
  rcs_arbiter #(.LOCKOUT_CYCLES(20'd20)) u_rcs_arbiter (.mclk(mclk), .rst_n(rst_n),
    .ctrl_rd(ctrl_rd), .ctrl_wr(ctrl_wr), .ctrl_addr(ctrl_addr), .ctrl_wdata(ctrl_wdata),
    .ctrl_rdata(ctrl_rdata), .host_req(host_req), .host_rdata(host_rdata),
    .host_power_good(pg), .standby_supply(sby), .system_reset_output_n(sysrst_n),
    .total_power_loss(loss), .divider_normal(div_n), .cmos_req(cmos_req),
    .cmos_rdata(cmos_rdata), .osc_disable(osc), .host_locked(host_locked),
    .rtc_irq_oe(irq_oe), .rtc_irq_req(irq));
  rcs_cmos_model u_rcs_cmos_model (.mclk(mclk), .cmos_req(cmos_req), .cmos_rdata(cmos_rdata));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  initial begin
    forever #2 mclk = ~mclk;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one-cycle controller write strobe
  task automatic cw(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk) #1 {ctrl_wr, ctrl_addr, ctrl_wdata} = {1'b1, a, d};
    @(posedge mclk) #1 ctrl_wr = 0;
  endtask : cw
  // read, then compare the byte registered for the next cycle
  task automatic cr(input logic [15:0] a, input logic [7:0] exp);
    @(posedge mclk) #1 {ctrl_rd, ctrl_addr} = {1'b1, a};
    @(posedge mclk) #1 ctrl_rd = 0;
    check(ctrl_rdata, exp);
  endtask : cr
  // host write strobe to one cmos location; 7F or FF is the control mirror
  task automatic hw(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) #1 host_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge mclk) #1 host_req = '0;
  endtask : hw
  // host read, then compare the byte registered for the next cycle
  task automatic hr(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk) #1 host_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge mclk) #1 host_req = '0;
    check(host_rdata, exp);
  endtask : hr
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    cr(`RCS_OFS_CONTROL, 8'h80);
    cr(`RCS_OFS_ADDR_LO, 8'h00);
    cr(`RCS_OFS_ADDR_HI, 8'h00);
    $display("test reset values done");
  endtask : t_reset
  task automatic t_low();
    cw(`RCS_OFS_CONTROL, 8'h72); // bits 6-4 written high
    cr(`RCS_OFS_CONTROL, 8'h02);
    hw(8'h7F, 8'h01);
    cr(`RCS_OFS_CONTROL, 8'h02);
    cw(`RCS_OFS_ADDR_LO, 8'h85);
    cw(`RCS_OFS_DATA_LO, 8'h5A);
    cr(`RCS_OFS_DATA_LO, 8'h5A);
    cr(`RCS_OFS_DATA_HI, 8'h00);
    $display("test low bank done");
  endtask : t_low
  task automatic t_high();
    cw(`RCS_OFS_CONTROL, 8'h00);
    hw(8'hFF, 8'h04);
    cw(`RCS_OFS_CONTROL, 8'h08);
    cr(`RCS_OFS_CONTROL, 8'h04);
    cw(`RCS_OFS_CONTROL, 8'h80);
    cr(`RCS_OFS_CONTROL, 8'h80);
    $display("test high bank done");
  endtask : t_high
  task automatic t_lock();
    hw(8'h10, 8'h11); // host owns both banks while unaware
    @(posedge mclk) #1 pg = 0;
    repeat (4) @(posedge mclk);
    #1 check({7'h00, host_locked}, 8'h01);
    hw(8'h10, 8'hEE);
    cw(`RCS_OFS_CONTROL, 8'h00);
    pg = 1;
    hw(8'h7F, 8'h01);
    cr(`RCS_OFS_CONTROL, 8'h00);
    repeat (26) @(posedge mclk);
    #1 check({7'h00, host_locked}, 8'h00);
    hw(8'h7F, 8'h01);
    cr(`RCS_OFS_CONTROL, 8'h01);
    hr(8'h10, 8'h11);
    @(posedge mclk) #1 {pg, div_n} = 2'b00;
    @(posedge mclk) #1 check({7'h00, host_locked}, 8'h00);
    repeat (3) @(posedge mclk);
    hw(8'hFF, 8'h05);
    cr(`RCS_OFS_CONTROL, 8'h05);
    @(posedge mclk) #1 {pg, div_n} = 2'b11;
    $display("test lockout done");
  endtask : t_lock
  // reset output or standby loss frees the controller of arbitration
  task automatic t_free();
    @(posedge mclk) #1 sysrst_n = 0;
    repeat (3) @(posedge mclk);
    cw(`RCS_OFS_ADDR_HI, 8'h83);
    cw(`RCS_OFS_DATA_HI, 8'hA5);
    cr(`RCS_OFS_DATA_HI, 8'hA5);
    {sysrst_n, sby} = 2'b10;
    repeat (3) @(posedge mclk);
    cr(`RCS_OFS_DATA_HI, 8'hA5);
    sby = 1;
    repeat (3) @(posedge mclk);
    cr(`RCS_OFS_DATA_HI, 8'h00);
    hr(8'h83, 8'hA5);
    hr(8'hFF, 8'h05);
    $display("test controller free access done");
  endtask : t_free
  // total power loss zeroes 00-0D of bank 0 and stops the oscillator
  task automatic t_loss();
    cw(`RCS_OFS_CONTROL, 8'h80);
    cw(`RCS_OFS_CONTROL, 8'h0A);
    cr(`RCS_OFS_CONTROL, 8'h0A);
    cw(`RCS_OFS_ADDR_LO, 8'h0D);
    cw(`RCS_OFS_DATA_LO, 8'h3C);
    cr(`RCS_OFS_DATA_LO, 8'h3C);
    cw(`RCS_OFS_ADDR_HI, 8'h8D);
    cw(`RCS_OFS_DATA_HI, 8'h66);
    @(posedge mclk) #1 loss = 1;
    repeat (20) @(posedge mclk);
    #1 check({7'h00, osc}, 8'h01);
    cr(`RCS_OFS_DATA_LO, 8'h00);
    cr(`RCS_OFS_DATA_HI, 8'h66);
    loss = 0;
    repeat (4) @(posedge mclk);
    #1 check({7'h00, osc}, 8'h00);
    $display("test power loss done");
  endtask : t_loss
  // second power-on reset with a stray write held across it
  task automatic t_por();
    @(posedge mclk) #1 irq = 1;
    @(posedge mclk) #1 check({7'h00, irq_oe}, 8'h01);
    {rst_n, ctrl_wr, ctrl_addr, ctrl_wdata} = {2'b01, `RCS_OFS_DATA_LO, 8'hEE};
    @(posedge mclk) #1 check({7'h00, irq_oe}, 8'h00);
    {rst_n, ctrl_wr, irq} = 3'b100;
    repeat (3) @(posedge mclk);
    cr(`RCS_OFS_CONTROL, 8'h80);
    hr(8'h00, 8'h00);
    $display("test mid-run reset done");
  endtask : t_por
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  // hang guard well above the run length
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    repeat (2) @(posedge mclk);
    #1 rst_n = 1;
    repeat (30) @(posedge mclk);
    t_reset();
    t_low();
    t_high();
    t_lock();
    t_free();
    t_loss();
    t_por();
    conclude();
  end
endmodule : rcs_arbiter_tb
`default_nettype wire

// *** test/rcs_cmos_model.sv ***
// Purpose: battery-backed cmos array seen behind the arbiter
// Assumes: writes land on the mclk edge, reads are combinational
// Notes: bit 7 of the address picks the bank
`timescale 1ns/1ps
`default_nettype none
module rcs_cmos_model
  import rcs_pkg::*;
(
  // clock
  input wire logic mclk,
  // array port
  input wire rcs_cmos_req_s cmos_req,
  output logic [7:0] cmos_rdata
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [7:0] mem [0:255]; // both banks, unset bytes read as x
  // read: idle port shows a changing pattern, not stale data
  assign cmos_rdata = cmos_req.rd ? mem[cmos_req.addr] : ~cmos_req.addr;
  // write on the edge that takes the strobe
  always @(posedge mclk) begin
    if (cmos_req.wr) begin
      mem[cmos_req.addr] <= cmos_req.wdata;
    end
  end
endmodule : rcs_cmos_model
`default_nettype wire
